// ---- hw/lsot_map.svh ----
// register indices, field positions, reset values and timing counts of the sink dark timers
`ifndef LSOT_MAP_SVH
`define LSOT_MAP_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define LSOT_IDX_SINK7   8'h1F
`define LSOT_IDX_SINK8   8'h20
`define LSOT_IDX_SINK9   8'h21
`define LSOT_IDX_FADE    8'h22
`define LSOT_IDX_CTRL    8'h30
`define LSOT_IDX_STAT    8'h31

// ==========================================================
// fields and reset values
`define LSOT_CODE_MSB    6
`define LSOT_FADE_MSB    7
`define LSOT_FADE_LSB    4
`define LSOT_CODE_DIS    7'h00
`define LSOT_CODE_HOLD   7'h7F
`define LSOT_REG_RST     8'h00
`define LSOT_CTRL_RST    3'h0

// ==========================================================
// timing: one tick is 50 ms, a dark step of 0.1 s is two ticks
`define LSOT_CLK_KHZ     100000
`define LSOT_TICK_MS     50
`define LSOT_TICK_CYC    (`LSOT_TICK_MS * `LSOT_CLK_KHZ)
`define LSOT_STEP_MS     100
`define LSOT_STEP_TICKS  (`LSOT_STEP_MS / `LSOT_TICK_MS)

`endif

// ---- hw/lsot_pkg.sv ----
// types shared by the sink dark timer block
package lsot_pkg;

    // ==========================================================
    // per-sink phase
    typedef enum logic [2:0] {
        ST_OFF,
        ST_LIT,
        ST_FADE,
        ST_DARK,
        ST_HOLD
    } lsot_state_e;

    typedef logic [31:0] lsot_word_t;
    typedef logic [11:0] lsot_addr_t;
    typedef logic [6:0]  lsot_code_t;
    typedef logic [7:0]  lsot_cnt_t;

endpackage : lsot_pkg

// ---- hw/lsot_timer.sv ----
// dark-interval timers of sinks 7, 8 and 9 with apb register access
// Functional notes
// R1: sinks 7, 8, 9 each own a 7-bit dark code, bit 7 reserved.
// R2: code zero keeps an enabled sink lit with no dark phase.
// R3: other codes darken the sink, then relight it per lit-interval setting.
// R4: code 1 is 0.0 s, each step adds 0.1 s, code 126 is 12.5 s.
// R5: code all ones holds the sink dark forever once it turns off.
// R6: software avoids zero dark time together with zero fade-down time.
// R7: after a timed dark phase the sink relights, phases alternate while enabled.
// R8: fade-down field is 4 bits [7:4]; 0 disables, 1 is 0.05 s.
// R9: dark counters use the shared timebase and restart at each dark phase.
`include "lsot_map.svh"

module lsot_timer #(
    parameter int unsigned TICK_CYC = `LSOT_TICK_CYC
) (
    // clock, reset, clock enable
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire lsot_pkg::lsot_addr_t paddr,
    input  wire lsot_pkg::lsot_word_t pwdata,
    output lsot_pkg::lsot_word_t   prdata,
    output logic                   pready,
    output logic                   pslverr,
    // lit-interval timer handshake, bit 0 is sink 7
    input  wire logic [2:0]        lit_expired,
    output logic [2:0]             lit_restart,
    // sink drive
    output logic [2:0]             sink_on
);
    import lsot_pkg::*;

    // ==========================================================
    // functions
    function automatic lsot_addr_t byte_addr(input logic [7:0] idx);
        byte_addr = {2'b00, idx, 2'b00};
    endfunction : byte_addr

    function automatic lsot_cnt_t dark_ticks(input lsot_code_t c);
        lsot_cnt_t base;
        base = 8'(c) - 8'h01;
        if (c == `LSOT_CODE_DIS) begin
            dark_ticks = 8'h00;
        end else begin
            dark_ticks = 8'(base * `LSOT_STEP_TICKS); // R4
        end
    endfunction : dark_ticks

    function automatic lsot_cnt_t fade_ticks(input logic [3:0] f);
        lsot_cnt_t over;
        over = 8'(f) - 8'h0A;
        if (f <= 4'hA) begin
            fade_ticks = 8'(f); // R8
        end else begin
            fade_ticks = 8'(over * 8'h05) + 8'h0A;
        end
    endfunction : fade_ticks

    // ==========================================================
    // registers
    lsot_code_t       code_r [3];
    logic [7:0]       fade_r;
    logic [2:0]       ctrl_r;
    lsot_word_t       prdata_r;
    logic [22:0]      tb_cnt_r;
    logic             tick_r;
    logic [2:0]       sink_on_r;
    logic [2:0]       lit_restart_r;
    logic [2:0]       dark_w;
    logic [2:0]       hold_w;

    // ==========================================================
    // apb decode
    wire logic        setup_w   = psel & ~penable & ce;
    wire logic        access_w  = psel & penable & ce;
    wire logic        hit_s7_w  = (paddr == byte_addr(`LSOT_IDX_SINK7));
    wire logic        hit_s8_w  = (paddr == byte_addr(`LSOT_IDX_SINK8));
    wire logic        hit_s9_w  = (paddr == byte_addr(`LSOT_IDX_SINK9));
    wire logic        hit_fd_w  = (paddr == byte_addr(`LSOT_IDX_FADE));
    wire logic        hit_ct_w  = (paddr == byte_addr(`LSOT_IDX_CTRL));
    wire logic        hit_st_w  = (paddr == byte_addr(`LSOT_IDX_STAT));
    wire logic        hit_any_w = hit_s7_w | hit_s8_w | hit_s9_w
                                | hit_fd_w | hit_ct_w | hit_st_w;
    wire logic        wr_w      = access_w & pwrite;
    wire logic [2:0]  wr_code_w = {hit_s9_w, hit_s8_w, hit_s7_w} & {3{wr_w}};
    wire lsot_code_t  wcode_w   = pwdata[`LSOT_CODE_MSB:0];

    // ==========================================================
    // read mux, reserved bits read zero
    wire lsot_word_t  rd_mux_w =
        hit_s7_w ? {25'h000_0000, code_r[0]} : // R1
        hit_s8_w ? {25'h000_0000, code_r[1]} :
        hit_s9_w ? {25'h000_0000, code_r[2]} :
        hit_fd_w ? {24'h00_0000, fade_r} :
        hit_ct_w ? {29'h0000_0000, ctrl_r} :
        hit_st_w ? {23'h00_0000, hold_w, dark_w, sink_on_r} :
                   32'h0000_0000;

    assign pready      = ce;
    assign pslverr     = psel & penable & ~hit_any_w;
    assign prdata      = prdata_r;
    assign sink_on     = sink_on_r;
    assign lit_restart = lit_restart_r;

    // ==========================================================
    // register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fade_r <= `LSOT_REG_RST;
            ctrl_r <= `LSOT_CTRL_RST;
        end else if (wr_w) begin
            if (hit_fd_w) begin
                fade_r <= pwdata[7:0];
            end
            if (hit_ct_w) begin
                ctrl_r <= pwdata[2:0];
            end
        end
    end

    // read data captured in the setup phase, stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup_w) begin
            prdata_r <= pwrite ? 32'h0000_0000 : rd_mux_w;
        end
    end

    // ==========================================================
    // shared timebase
    wire logic        tb_wrap_w = (tb_cnt_r == 23'(TICK_CYC - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tb_cnt_r <= 23'h00_0000;
            tick_r   <= 1'b0;
        end else if (ce) begin
            tb_cnt_r <= tb_wrap_w ? 23'h00_0000 : tb_cnt_r + 23'h00_0001; // R9
            tick_r   <= tb_wrap_w;
        end
    end

    // ==========================================================
    // per-sink phase machines
    for (genvar k = 0; k < 3; k++) begin : g_sink
        lsot_state_e  st_r;
        lsot_state_e  st_nxt;
        lsot_cnt_t    cnt_r;
        lsot_cnt_t    cnt_nxt;
        logic         restart_nxt;
        lsot_code_t   code_w;
        lsot_cnt_t    fade_len_w;
        lsot_cnt_t    dark_len_w;
        lsot_state_e  dark_entry_w;

        assign code_w       = code_r[k];
        assign fade_len_w   = fade_ticks(fade_r[`LSOT_FADE_MSB:`LSOT_FADE_LSB]);
        assign dark_len_w   = dark_ticks(code_w);
        assign dark_entry_w = (code_w == `LSOT_CODE_HOLD) ? ST_HOLD : ST_DARK; // R5
        assign dark_w[k]    = (st_r == ST_DARK) | (st_r == ST_HOLD);
        assign hold_w[k]    = (st_r == ST_HOLD);

        always_comb begin
            st_nxt      = st_r;
            cnt_nxt     = cnt_r;
            restart_nxt = 1'b0;
            if (!ctrl_r[k]) begin
                st_nxt  = ST_OFF;
                cnt_nxt = 8'h00;
            end else begin
                unique case (st_r)
                    ST_OFF: begin
                        st_nxt      = ST_LIT;
                        restart_nxt = 1'b1;
                    end
                    ST_LIT: begin
                        // code zero never leaves the lit phase
                        if (code_w != `LSOT_CODE_DIS && lit_expired[k]) begin // R2
                            cnt_nxt = 8'h00;
                            st_nxt  = (fade_len_w != 8'h00) ? ST_FADE : dark_entry_w; // R3
                        end
                    end
                    ST_FADE: begin
                        if (cnt_r >= fade_len_w) begin // R8
                            st_nxt  = dark_entry_w;
                            cnt_nxt = 8'h00; // R9
                        end else if (tick_r) begin
                            cnt_nxt = cnt_r + 8'h01;
                        end
                    end
                    ST_DARK: begin
                        if (cnt_r >= dark_len_w) begin // R4
                            st_nxt      = ST_LIT; // R7
                            restart_nxt = 1'b1;
                            cnt_nxt     = 8'h00;
                        end else if (tick_r) begin
                            cnt_nxt = cnt_r + 8'h01; // R9
                        end
                    end
                    ST_HOLD: begin
                        st_nxt = ST_HOLD; // R5
                    end
                    // unused encodings of the 3-bit phase fall back to off
                    default: begin
                        st_nxt  = ST_OFF;
                        cnt_nxt = 8'h00;
                    end
                endcase
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                code_r[k] <= `LSOT_CODE_DIS;
            end else if (ce && wr_code_w[k]) begin
                code_r[k] <= wcode_w; // R1
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                st_r             <= ST_OFF;
                cnt_r            <= 8'h00;
                sink_on_r[k]     <= 1'b0;
                lit_restart_r[k] <= 1'b0;
            end else if (ce) begin
                st_r             <= st_nxt;
                cnt_r            <= cnt_nxt;
                sink_on_r[k]     <= (st_nxt == ST_LIT) | (st_nxt == ST_FADE);
                lit_restart_r[k] <= restart_nxt;
            end
        end
    end

endmodule : lsot_timer

// ---- verification/lsot_timer_monitor.sv ----
// concurrent checks on the ports of the sink dark timer block
module lsot_timer_monitor #(
    parameter int unsigned TICK_CYC = 4
) (
    // clock, reset, enable
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 ce,
    // apb
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire lsot_pkg::lsot_addr_t paddr,
    input wire lsot_pkg::lsot_word_t prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    // sinks
    input wire logic [2:0]           lit_restart,
    input wire logic [2:0]           sink_on
);
    import lsot_pkg::*;
    // ==========================================================
    // apb checks
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_access;
        psel && penable;
    endsequence
    a_ready_ce: assert property (pready == ce)
        else $error("pready differs from ce");
    a_err_idle: assert property (!psel |-> !pslverr)
        else $error("error flag outside a transfer");
    a_err_unmapped: assert property (s_access ##0 (paddr == 12'h000) |-> pslverr)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (s_access ##0 (paddr == 12'h07C) |-> !pslverr)
        else $error("mapped access refused");
    a_rdata_unmapped: assert property (s_access ##0 (!pwrite && paddr == 12'h000) |-> prdata == 0)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!psel |-> $stable(prdata))
        else $error("read data moved while idle");
    // ==========================================================
    // sink checks
    a_restart_edge: assert property ($past(ce) |-> lit_restart == (sink_on & ~$past(sink_on)))
        else $error("restart pulse not tied to relight");
    a_restart_lit: assert property ((lit_restart & ~sink_on) == 3'h0)
        else $error("restart while sink dark");
    a_freeze_ce: assert property (!ce |=> $stable(sink_on))
        else $error("sink moved with clock enable low");
endmodule : lsot_timer_monitor

bind lsot_timer lsot_timer_monitor #(.TICK_CYC(TICK_CYC)) u_lsot_timer_monitor (.pclk(pclk),
    .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lit_restart(lit_restart),
    .sink_on(sink_on));

// ---- verification/test_lsot_timer.sv ----
// self-checking bench of the sink dark timer block
module test_lsot_timer;
    timeunit 1ns;
    timeprecision 1ns;
    import lsot_pkg::*;
    localparam int TK = 4;
    `define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
        $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
    lsot_addr_t  paddr;
    lsot_word_t  pwdata, prdata, q, v;
    logic [2:0]  lit_expired, lit_restart, sink_on;
    logic [31:0] seed = 32'h0001_0322;
    int          error_cnt = 0, tests_run = 0, cyc = 0, n, s, c;
    lsot_timer #(.TICK_CYC(TK)) u_lsot_timer (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .lit_expired(lit_expired),
        .lit_restart(lit_restart), .sink_on(sink_on));
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // dark length in cycles, first tick may come early
    function bit dark_ok(int code, int cnt);
        int e;
        e = (code - 1) * 2 * TK + 1;
        return (cnt + TK >= e) && (cnt <= e + 1);
    endfunction : dark_ok
    task results();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results
    task apb(input logic wr, input lsot_addr_t a, input lsot_word_t d);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // end of lit phase, then count dark cycles
    task dark(input int sk);
        lit_expired[sk] <= 1'b1;
        @(posedge pclk);
        lit_expired <= 3'h0;
        n = 0;
        #1;
        while (sink_on[sk] === 1'b0 && n < 2000) begin
            n++;
            @(posedge pclk);
            #1;
        end
        @(posedge pclk);
    endtask : dark
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end
    initial begin
        {presetn, ce, psel, penable, pwrite, paddr, pwdata, lit_expired} = '0;
        ce = 1'b1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 12'h07C + 12'(4 * i), 32'h0000_0000);
            `CHK(q, 32'h0000_0000)
            v = rnd();
            apb(1'b1, 12'h07C + 12'(4 * i), v);
            apb(1'b0, 12'h07C + 12'(4 * i), 32'h0000_0000);
            `CHK(q, {25'h000_0000, v[6:0]})
        end
        apb(1'b0, 12'h000, 32'h0000_0000);
        `CHK({err, q}, 33'h0_0000_0000 | 33'h1_0000_0000)
        apb(1'b1, 12'h088, 32'h0000_00A5);
        apb(1'b0, 12'h088, 32'h0000_0000);
        `CHK(q, 32'h0000_00A5)
        $display("test registers finished");
        apb(1'b1, 12'h088, 32'h0000_0000);
        apb(1'b1, 12'h07C, 32'h0000_0000);
        apb(1'b1, 12'h0C0, 32'h0000_0007);
        dark(0);
        `CHK(sink_on[0], 1'b1)
        ce <= 1'b0;
        repeat (6) @(posedge pclk);
        ce <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            s = k % 2;
            c = (k == 0) ? 2 : 2 + rnd() % 19;
            apb(1'b1, 12'h07C + 12'(4 * s), 32'(c));
            dark(s);
            `CHK(dark_ok(c, n), 1'b1)
            `CHK(sink_on[s], 1'b1)
        end
        $display("test dark timing finished");
        apb(1'b1, 12'h088, 32'h0000_0010);
        apb(1'b1, 12'h084, 32'h0000_007F);
        lit_expired[2] <= 1'b1;
        @(posedge pclk);
        lit_expired <= 3'h0;
        #1;
        `CHK(sink_on[2], 1'b1)
        repeat (150) @(posedge pclk);
        #1;
        `CHK(sink_on[2], 1'b0)
        apb(1'b0, 12'h0C4, 32'h0000_0000);
        `CHK(q, 32'h0000_0123)
        $display("test hold finished");
        results();
    end
endmodule : test_lsot_timer
